// ==== include/touch_cfg_pkg.sv ====
`default_nettype none

package touch_cfg_pkg;

	// Register map
	localparam logic [7:0] SENSOR_SAMPLE_ENABLE_ADDR    = 8'h21;
	localparam logic [7:0] BUTTON_TIMING_CONFIG_ADDR    = 8'h22;
	localparam logic [7:0] GROUP_TIMING_CONFIG_ONE_ADDR = 8'h23;

	localparam logic [7:0] SENSOR_SAMPLE_ENABLE_RST    = 8'hff;
	localparam logic [7:0] BUTTON_TIMING_CONFIG_RST    = 8'ha4;
	localparam logic [7:0] GROUP_TIMING_CONFIG_ONE_RST = 8'h47;
	localparam logic [7:0] UNMAPPED_READ               = 8'h00;

	// Field positions
	localparam int GROUP_SAMPLE_ENABLE_BIT = 7;
	localparam int INPUT_ENABLE_MSB        = 6;
	localparam int HIGH_NIBBLE_LSB         = 4;
	localparam int LOW_NIBBLE_LSB          = 0;

	localparam int NUM_BUTTONS = 7;
	localparam int NUM_GROUPED = 7;

	// Time base
	localparam int CLK_KHZ       = 25000;
	localparam int TICK_MS       = 35;
	localparam int TICK_CYCLES   = TICK_MS * CLK_KHZ;
	localparam int TICK_CNT_W    = 20;
	localparam int ELAPSED_W     = 9;
	localparam int INTERVAL_W    = 5;

	// Hold limit per code, in milliseconds
	localparam int HOLD_LIMIT_MS [16] = '{
		560, 840, 1120, 1400, 1680, 2240, 2800, 3360,
		3920, 4480, 5600, 6720, 7840, 8906, 10080, 11200
	};

	// Longest time: rounds down to whole ticks
	function automatic logic [ELAPSED_W-1:0] hold_limit_ticks(input logic [3:0] code);
		int ms;
		ms = HOLD_LIMIT_MS[code];
		return ELAPSED_W'(ms / TICK_MS);
	endfunction

	// Interval of (code + 1) ticks
	function automatic logic [INTERVAL_W-1:0] interval_ticks(input logic [3:0] code);
		return {1'b0, code} + 5'h01;
	endfunction

endpackage

`default_nettype wire

// ==== logic/touch_duration_timer.sv ====
`timescale 1ns/10ps
`default_nettype none

module touch_duration_timer #(
	parameter bit GROUPED = 1'b0
) (
	input  wire logic                                clk,
	input  wire logic                                rst,
	input  wire logic                                tick,
	input  wire logic                                touch,
	input  wire logic [touch_cfg_pkg::ELAPSED_W-1:0]  limit_ticks,
	input  wire logic [touch_cfg_pkg::INTERVAL_W-1:0] repeat_ticks,
	input  wire logic [touch_cfg_pkg::INTERVAL_W-1:0] thresh_ticks,
	input  wire logic                                repeat_en,
	output logic                                     start_pulse,
	output logic                                     limit_pulse,
	output logic                                     hold_pulse,
	output logic                                     tap_pulse,
	output logic                                     repeat_pulse
);
	import touch_cfg_pkg::*;

	logic                  touch_q;
	logic                  held_q;
	logic [ELAPSED_W-1:0]  elapsed_q;
	logic [INTERVAL_W-1:0] rep_cnt_q;
	logic                  rep_armed;

	assign start_pulse  = touch & ~touch_q;
	// Elapsed passes the limit on the tick that takes it above it
	assign limit_pulse  = touch & ~start_pulse & tick & (elapsed_q == limit_ticks);
	assign hold_pulse   = GROUPED & touch & ~start_pulse & ~held_q & tick
		& (elapsed_q == ELAPSED_W'(thresh_ticks));
	assign tap_pulse    = GROUPED & ~touch & touch_q & ~held_q;
	assign rep_armed    = touch & ~start_pulse & repeat_en & (GROUPED ? held_q : 1'b1);
	assign repeat_pulse = rep_armed & tick & (rep_cnt_q + 5'h01 == repeat_ticks);

	always_ff @(posedge clk) begin
		if (rst) begin
			touch_q <= 1'b0;
		end else begin
			touch_q <= touch;
		end
	end

	// Counts from touch detection on the common time base
	always_ff @(posedge clk) begin
		if (rst || start_pulse || !touch) begin
			elapsed_q <= '0;
		end else if (tick && elapsed_q != '1) begin
			elapsed_q <= elapsed_q + 9'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !touch) begin
			held_q <= 1'b0;
		end else if (hold_pulse) begin
			held_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !rep_armed || repeat_pulse) begin
			rep_cnt_q <= '0;
		end else if (tick) begin
			rep_cnt_q <= rep_cnt_q + 5'h01;
		end
	end

	AST_TAP_NOT_HOLD: assert property (@(posedge clk) disable iff (rst)
		tap_pulse |-> !$past(held_q) && !hold_pulse)
		else $error("tap reported after press-and-hold");

endmodule

`default_nettype wire

// ==== logic/touch_sample_timing.sv ====
// Operation
// - In full activity an ungrouped input is sampled only when its enable bit is one.
// - The sampling cycle keeps one fixed length whatever inputs are enabled.
// - With the group enable bit low no grouped sensor is sampled, regardless of the volume flag.
// - Bits 6..0 of the sample-enable register enable inputs seven..one and reset to all ones.
// - The button timing upper nibble sets the hold limit and resets to code 1010 (5600 ms).
// - Hold-limit codes 0..15 select 560 through 11200 ms in the printed order.
// - The button timing lower nibble sets the held-button repeat interval and resets to 0100.
// - A repeat code selects 35 ms times code plus one, default 175 ms.
// - Group timing upper nibble sets the group press-and-hold repeat interval, reset 0100.
// - A grouped touch longer than the hold threshold is a press-and-hold event.
// - A grouped touch no longer than the hold threshold is a tap event.
// - The hold threshold does not affect slide detection, reported as its own event.
// - The hold threshold code selects 35 ms times code plus one, reset 0111 (280 ms).
// - With the hold-limit enable set, an ungrouped button press beyond the limit restarts recalibration; grouped presses do not.
// - Without repeat one interrupt per touch, with repeat one per interval while held.
`timescale 1ns/10ps
`default_nettype none

module touch_sample_timing #(
	parameter int TICK_CYCLES = touch_cfg_pkg::TICK_CYCLES
) (
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	input  wire logic [7:0]                           reg_addr,
	input  wire logic                                 reg_wr,
	input  wire logic                                 reg_rd,
	input  wire logic [7:0]                           reg_wdata,
	output logic      [7:0]                           reg_rdata,
	input  wire logic                                 fully_active,
	input  wire logic                                 button_hold_limit_enable,
	input  wire logic                                 button_repeat_enable,
	input  wire logic                                 group_repeat_enable,
	input  wire logic                                 volume_direction_flag,
	input  wire logic [touch_cfg_pkg::NUM_GROUPED-1:0] group_channel_enable,
	input  wire logic [touch_cfg_pkg::NUM_BUTTONS-1:0] button_touch,
	input  wire logic [touch_cfg_pkg::NUM_GROUPED-1:0] group_touch,
	input  wire logic                                 slide_detect,
	output logic                                      sample_start,
	output logic      [touch_cfg_pkg::NUM_BUTTONS-1:0] button_sample,
	output logic      [touch_cfg_pkg::NUM_GROUPED-1:0] group_sample,
	output logic      [touch_cfg_pkg::NUM_BUTTONS-1:0] button_event,
	output logic      [touch_cfg_pkg::NUM_BUTTONS-1:0] recal_request,
	output logic      [touch_cfg_pkg::NUM_GROUPED-1:0] tap_event,
	output logic      [touch_cfg_pkg::NUM_GROUPED-1:0] hold_event,
	output logic      [touch_cfg_pkg::NUM_GROUPED-1:0] hold_repeat_event,
	output logic                                      slide_event,
	output logic                                      volume_direction
);
	import touch_cfg_pkg::*;

	logic [7:0]            sensor_sample_enable_q;
	logic [7:0]            button_timing_config_q;
	logic [7:0]            group_timing_config_one_q;
	logic [TICK_CNT_W-1:0] tick_cnt_q;
	logic                  tick;
	logic                  group_sample_enable;
	logic [ELAPSED_W-1:0]  button_hold_limit;
	logic [INTERVAL_W-1:0] button_repeat_interval;
	logic [INTERVAL_W-1:0] group_hold_repeat_interval;
	logic [INTERVAL_W-1:0] group_hold_threshold;
	logic [NUM_BUTTONS-1:0] btn_start;
	logic [NUM_BUTTONS-1:0] btn_repeat;
	logic [NUM_BUTTONS-1:0] btn_limit;
	logic [NUM_BUTTONS-1:0] btn_touch_gated;
	logic [NUM_GROUPED-1:0] grp_touch_gated;
	logic [NUM_GROUPED-1:0] grp_repeat;
	logic [NUM_GROUPED-1:0] grp_tap;
	logic [NUM_BUTTONS-1:0] btn_unused_tap;
	logic [NUM_BUTTONS-1:0] btn_unused_hold;
	logic [NUM_GROUPED-1:0] grp_unused_start;
	logic [NUM_GROUPED-1:0] grp_unused_limit;
	logic [7:0]            rdata_d;
	logic [7:0]            rdata_q;

	// Register writes
	always_ff @(posedge clk) begin
		if (rst) begin
			sensor_sample_enable_q <= SENSOR_SAMPLE_ENABLE_RST;
		end else if (reg_wr && reg_addr == SENSOR_SAMPLE_ENABLE_ADDR) begin
			sensor_sample_enable_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			button_timing_config_q <= BUTTON_TIMING_CONFIG_RST;
		end else if (reg_wr && reg_addr == BUTTON_TIMING_CONFIG_ADDR) begin
			button_timing_config_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			group_timing_config_one_q <= GROUP_TIMING_CONFIG_ONE_RST;
		end else if (reg_wr && reg_addr == GROUP_TIMING_CONFIG_ONE_ADDR) begin
			group_timing_config_one_q <= reg_wdata;
		end
	end

	// Register reads; unmapped addresses return zero
	always_comb begin
		unique case (reg_addr)
			SENSOR_SAMPLE_ENABLE_ADDR:    rdata_d = sensor_sample_enable_q;
			BUTTON_TIMING_CONFIG_ADDR:    rdata_d = button_timing_config_q;
			GROUP_TIMING_CONFIG_ONE_ADDR: rdata_d = group_timing_config_one_q;
			default:                      rdata_d = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= UNMAPPED_READ;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// Field decode
	assign group_sample_enable        = sensor_sample_enable_q[GROUP_SAMPLE_ENABLE_BIT];
	assign button_hold_limit          = hold_limit_ticks(button_timing_config_q[HIGH_NIBBLE_LSB +: 4]);
	assign button_repeat_interval     = interval_ticks(button_timing_config_q[LOW_NIBBLE_LSB +: 4]);
	assign group_hold_repeat_interval = interval_ticks(group_timing_config_one_q[HIGH_NIBBLE_LSB +: 4]);
	assign group_hold_threshold       = interval_ticks(group_timing_config_one_q[LOW_NIBBLE_LSB +: 4]);

	// Common 35 ms time base; also the fixed sampling cycle
	always_ff @(posedge clk) begin
		if (rst || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 20'h0_0001;
		end
	end

	assign tick         = (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1));
	assign sample_start = tick & fully_active;

	// Per-input sampling strobes; skipped inputs leave an idle slot
	assign button_sample = {NUM_BUTTONS{sample_start}}
		& sensor_sample_enable_q[INPUT_ENABLE_MSB:0];
	assign group_sample  = {NUM_GROUPED{sample_start & group_sample_enable}}
		& group_channel_enable;
	assign volume_direction = volume_direction_flag & group_sample_enable;

	// Only enabled channels can report touches
	assign btn_touch_gated = button_touch & sensor_sample_enable_q[INPUT_ENABLE_MSB:0];
	assign grp_touch_gated = group_touch & group_channel_enable
		& {NUM_GROUPED{group_sample_enable}};

	generate
		for (genvar i = 0; i < NUM_BUTTONS; i++) begin : g_button
			touch_duration_timer #(
				.GROUPED (1'b0)
			) u_timer (
				.clk          (clk),
				.rst          (rst),
				.tick         (tick),
				.touch        (btn_touch_gated[i]),
				.limit_ticks  (button_hold_limit),
				.repeat_ticks (button_repeat_interval),
				.thresh_ticks (group_hold_threshold),
				.repeat_en    (button_repeat_enable),
				.start_pulse  (btn_start[i]),
				.limit_pulse  (btn_limit[i]),
				.hold_pulse   (btn_unused_hold[i]),
				.tap_pulse    (btn_unused_tap[i]),
				.repeat_pulse (btn_repeat[i])
			);
		end
		for (genvar j = 0; j < NUM_GROUPED; j++) begin : g_group
			touch_duration_timer #(
				.GROUPED (1'b1)
			) u_timer (
				.clk          (clk),
				.rst          (rst),
				.tick         (tick),
				.touch        (grp_touch_gated[j]),
				.limit_ticks  (button_hold_limit),
				.repeat_ticks (group_hold_repeat_interval),
				.thresh_ticks (group_hold_threshold),
				.repeat_en    (group_repeat_enable),
				.start_pulse  (grp_unused_start[j]),
				.limit_pulse  (grp_unused_limit[j]),
				.hold_pulse   (hold_event[j]),
				.tap_pulse    (grp_tap[j]),
				.repeat_pulse (grp_repeat[j])
			);
		end
	endgenerate

	assign button_event      = btn_start | (btn_repeat & {NUM_BUTTONS{button_repeat_enable}});
	assign recal_request     = btn_limit & {NUM_BUTTONS{button_hold_limit_enable}};
	assign hold_repeat_event = grp_repeat;
	// A touch cut off by disabling the group is not a tap
	assign tap_event         = grp_tap & {NUM_GROUPED{group_sample_enable}};
	// Slides bypass the hold threshold entirely
	assign slide_event       = slide_detect & group_sample_enable;

	AST_SAMPLE_GATED: assert property (@(posedge clk) disable iff (rst)
		(button_sample & ~sensor_sample_enable_q[INPUT_ENABLE_MSB:0]) == '0)
		else $error("disabled input sampled");

	AST_CYCLE_FIXED: assert property (@(posedge clk) disable iff (rst)
		sample_start |-> tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1))
		else $error("sampling cycle length disturbed");

	AST_GROUP_OFF: assert property (@(posedge clk) disable iff (rst)
		!group_sample_enable |-> group_sample == '0 && hold_event == '0 && tap_event == '0
			&& !volume_direction)
		else $error("grouped sensor active while group disabled");

	AST_RESET_VALUES: assert property (@(posedge clk)
		$past(rst) && !rst |-> sensor_sample_enable_q == SENSOR_SAMPLE_ENABLE_RST
			&& button_timing_config_q == BUTTON_TIMING_CONFIG_RST
			&& group_timing_config_one_q == GROUP_TIMING_CONFIG_ONE_RST)
		else $error("register reset value wrong");

	AST_HOLD_REPEAT_GATED: assert property (@(posedge clk) disable iff (rst)
		!group_repeat_enable |-> hold_repeat_event == '0)
		else $error("hold repeat without repeat enable");

	AST_HOLD_MAP: assert property (@(posedge clk) disable iff (rst)
		button_timing_config_q[7:4] == 4'ha |-> button_hold_limit == 9'd160)
		else $error("hold limit decode wrong");

	AST_REPEAT_MAP: assert property (@(posedge clk) disable iff (rst)
		button_repeat_interval == {1'b0, button_timing_config_q[3:0]} + 5'd1)
		else $error("repeat interval decode wrong");

	AST_THRESH_MAP: assert property (@(posedge clk) disable iff (rst)
		group_timing_config_one_q[3:0] == 4'h7 |-> group_hold_threshold == 5'd8)
		else $error("hold threshold decode wrong");

	AST_RECAL_ENABLE: assert property (@(posedge clk) disable iff (rst)
		!button_hold_limit_enable |-> recal_request == '0)
		else $error("recalibration without hold limit enable");

	AST_SINGLE_IRQ: assert property (@(posedge clk) disable iff (rst)
		!button_repeat_enable |-> button_event == (btn_touch_gated & ~$past(btn_touch_gated)))
		else $error("extra button interrupt without repeat");

	AST_SLIDE_EVENT: assert property (@(posedge clk) disable iff (rst)
		slide_detect && group_sample_enable |-> slide_event)
		else $error("slide lost");

	COV_HOLD: cover property (@(posedge clk) disable iff (rst) hold_event != '0);
	COV_TAP: cover property (@(posedge clk) disable iff (rst) tap_event != '0);
	COV_HOLD_REPEAT: cover property (@(posedge clk) disable iff (rst) hold_repeat_event != '0);
	COV_RECAL: cover property (@(posedge clk) disable iff (rst) recal_request != '0);
	COV_REPEAT: cover property (@(posedge clk) disable iff (rst)
		button_repeat_enable && (btn_repeat != '0));

endmodule

`default_nettype wire

// ==== tb/touch_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module touch_host_model (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	// Released address and data lines show the inverse, never the old value
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		d = reg_rdata;
	endtask
endmodule

`default_nettype wire

// ==== tb/touch_sample_timing_test.sv ====
`timescale 1ns/10ps
`default_nettype none

module touch_sample_timing_test;
	import touch_cfg_pkg::*;
	localparam int T = 10;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       reg_wr, reg_rd, fa, hle, bre, gre, vdf, slide;
	logic [6:0] gce, bt, gt;
	logic       sample_start, slide_event, volume_direction;
	logic [6:0] button_sample, group_sample, button_event, recal_request;
	logic [6:0] tap_event, hold_event, hold_repeat_event;
	int         mismatches, samples_checked, n_ev, n_rc, n_tap, n_hold, n_rep;

	always #20 clk = ~clk;

	touch_sample_timing #(.TICK_CYCLES(T)) touch_sample_timing_inst (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fully_active(fa),
		.button_hold_limit_enable(hle), .button_repeat_enable(bre),
		.group_repeat_enable(gre), .volume_direction_flag(vdf),
		.group_channel_enable(gce), .button_touch(bt), .group_touch(gt),
		.slide_detect(slide), .sample_start(sample_start), .button_sample(button_sample),
		.group_sample(group_sample), .button_event(button_event),
		.recal_request(recal_request), .tap_event(tap_event), .hold_event(hold_event),
		.hold_repeat_event(hold_repeat_event), .slide_event(slide_event),
		.volume_direction(volume_direction));

	touch_host_model touch_host_model_inst (
		.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		touch_host_model_inst.read_reg(a, d);
		check({24'h0, d}, {24'h0, exp});
	endtask

	// Four sampling periods from any phase hold exactly four strobes
	task automatic scan(input logic [6:0] eb, input logic [6:0] eg, input int exp_n);
		int n;
		n = 0;
		repeat (4 * T) begin
			@(posedge clk);
			if (sample_start === 1'b1) begin
				n++;
				check({25'h0, button_sample}, {25'h0, eb});
				check({25'h0, group_sample}, {25'h0, eg});
			end
		end
		check(n, exp_n);
	endtask

	// Touch rises just after a tick and lasts n and a half sampling periods
	task automatic press(input bit grp, input int idx, input int n);
		n_ev = 0;
		n_rc = 0;
		n_tap = 0;
		n_hold = 0;
		n_rep = 0;
		do @(posedge clk); while (sample_start !== 1'b1);
		if (grp)
			gt[idx] <= 1'b1;
		else
			bt[idx] <= 1'b1;
		for (int i = 0; i < n * T + T / 2 + 3; i++) begin
			@(posedge clk);
			n_ev += $countones(button_event);
			n_rc += $countones(recal_request);
			n_tap += $countones(tap_event);
			n_hold += $countones(hold_event);
			n_rep += $countones(hold_repeat_event);
			if (i == n * T + T / 2 - 1) begin
				bt <= 7'h00;
				gt <= 7'h00;
			end
		end
	endtask

	initial begin
		#2800000;
		mismatches++;
		give_verdict();
	end

	initial begin
		int lim;
		mismatches = 0;
		samples_checked = 0;
		{fa, hle, bre, gre, vdf, slide} = 6'b110010;
		gce = 7'h55;
		bt = 7'h00;
		gt = 7'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h21, 8'hff);
		rd_chk(8'h22, 8'ha4);
		rd_chk(8'h23, 8'h47);
		rd_chk(8'h30, 8'h00);
		scan(7'h7f, 7'h55, 4);
		touch_host_model_inst.write_reg(8'h21, 8'h0f);
		rd_chk(8'h21, 8'h0f);
		scan(7'h0f, 7'h00, 4);
		check({31'h0, volume_direction}, 32'h0);
		slide <= 1'b1;
		@(posedge clk);
		check({31'h0, slide_event}, 32'h0);
		slide <= 1'b0;
		touch_host_model_inst.write_reg(8'h21, 8'hff);
		slide <= 1'b1;
		@(posedge clk);
		check({31'h0, slide_event}, 32'h1);
		check({31'h0, volume_direction}, 32'h1);
		slide <= 1'b0;
		fa <= 1'b0;
		scan(7'h00, 7'h00, 0);
		fa <= 1'b1;
		touch_host_model_inst.write_reg(8'h22, 8'h01);
		bre <= 1'b1;
		press(1'b0, 2, 9);
		check(n_ev, 5);
		touch_host_model_inst.write_reg(8'h21, 8'hfb);
		press(1'b0, 2, 3);
		check(n_ev, 0);
		touch_host_model_inst.write_reg(8'h21, 8'hff);
		bre <= 1'b0;
		for (int c = 0; c < 16; c++) begin
			lim = HOLD_LIMIT_MS[c] / TICK_MS;
			touch_host_model_inst.write_reg(8'h22, {c[3:0], 4'h4});
			press(1'b0, 0, lim - 1);
			check(n_rc, 0);
			press(1'b0, 0, lim + 1);
			check(n_rc, 1);
			check(n_ev, 1);
		end
		touch_host_model_inst.write_reg(8'h22, 8'h04);
		hle <= 1'b0;
		press(1'b0, 0, 17);
		check(n_rc, 0);
		touch_host_model_inst.write_reg(8'h23, 8'h02);
		press(1'b1, 0, 2);
		check(n_tap, 1);
		check(n_hold, 0);
		press(1'b1, 0, 4);
		check(n_hold, 1);
		check(n_tap, 0);
		gre <= 1'b1;
		touch_host_model_inst.write_reg(8'h23, 8'h12);
		press(1'b1, 0, 9);
		check(n_hold, 1);
		check(n_rep, 2);
		gre <= 1'b0;
		touch_host_model_inst.write_reg(8'h21, 8'h7f);
		press(1'b1, 0, 4);
		check(n_hold + n_tap, 0);
		give_verdict();
	end
endmodule

`default_nettype wire
